// ===== verilog/afc_pkg.sv
// constants for the audio function configuration register bank
// What this block does
// - subsystem_ident takes only the first write after reset, always reads back
// - identifier, codec id, config and power words survive D3hot to D0
// - first_feature_pointer is read-only and returns 50h
// - irq_routing_note is free read/write, resets 00h, steers nothing
// - irq_pin_select reads 02h, low bits 010b, bits 7:3 reserved
// - audio interrupt request is ORed with shared_irq_b toward the controller
// - codec_slot_ids resets 09h, third code bits 3:2, second code bits 1:0
// - codec id leaves on link_serial_out most significant bit first
// - secondary or tertiary access puts its code into slot 0 bits 1:0
// - io_decode_unlock clear makes io enable and bars 10h, 14h read-only
// - io_decode_unlock clear forces bit 0 of both io bars to zero
// - pm_feature_ident_reg reads 0001h, upper byte 00h ends list
// - power_mgmt_features reads C9C2h, bits 15:11 read 11001b, wake from D3cold, D3hot and D0
// - bits 8:6 report 375 mA aux current, bits 10:9 and 4 reserved
// - bit 5 says no device-specific initialization is needed
// - bit 3 says bus clock not needed for a wake event
// - bits 2:0 report power management revision 1.1
// - bus mastering io bar read-only until unlock, type bit tracks unlock
package afc_pkg;
    // ------------------------------------------------------------
    // byte offsets in configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND    = 8'h04;
    localparam logic [7:0] OFS_MIXER_BAR  = 8'h10;
    localparam logic [7:0] OFS_BM_BAR     = 8'h14;
    localparam logic [7:0] OFS_SUBSYS     = 8'h2E;
    localparam logic [7:0] OFS_FIRST_FEATURE_POINTER    = 8'h34;
    localparam logic [7:0] OFS_IRQ_LINE   = 8'h3C;
    localparam logic [7:0] OFS_IRQ_PIN    = 8'h3D;
    localparam logic [7:0] OFS_CODEC_IDS  = 8'h40;
    localparam logic [7:0] OFS_CONFIG     = 8'h41;
    localparam logic [7:0] OFS_PM_IDENT   = 8'h50;
    localparam logic [7:0] OFS_PM_FEAT    = 8'h52;
    // ------------------------------------------------------------
    // reset and fixed values
    // ------------------------------------------------------------
    localparam logic [15:0] SUBSYS_RST    = 16'h0000;
    localparam logic [7:0]  FIRST_FEATURE_POINTER_VAL   = 8'h50;
    localparam logic [7:0]  IRQ_LINE_RST  = 8'h00;
    localparam logic [7:0]  IRQ_PIN_VAL   = 8'h02;
    localparam logic [7:0]  CODEC_IDS_RST = 8'h09;
    localparam logic [7:0]  CONFIG_RST    = 8'h00;
    localparam logic [15:0] PM_IDENT_VAL  = 16'h0001;
    localparam logic [15:0] PM_FEAT_VAL   = 16'hC9C2;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SECOND_CODE_LSB = 0;
    localparam int THIRD_CODE_LSB  = 2;
    localparam int UNLOCK_BIT      = 0;
    localparam int IO_ENABLE_BIT   = 0;
    localparam int BAR_TYPE_BIT    = 0;
    localparam int MIXER_BASE_LSB  = 8;
    localparam int BM_BASE_LSB     = 6;
    localparam logic [15:0] MIXER_BASE_MASK = 16'hFF00;
    localparam logic [15:0] BM_BASE_MASK    = 16'hFFC0;
    // codec selector values on the codec access port
    localparam logic [1:0] SEL_PRIMARY   = 2'h0;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;
    localparam logic [1:0] SEL_TERTIARY  = 2'h2;
endpackage : afc_pkg

// ===== verilog/afc_id_shifter.sv
// serializer for the two-bit codec id inside slot 0
`timescale 1ns/10ps
module afc_id_shifter
    import afc_pkg::*;
(
    // clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       RSTN,
    // slot 0 framing
    input  wire logic       load,
    input  wire logic       shift,
    input  wire logic [1:0] code,
    // serial result
    output logic            bit_out
);
    logic [1:0] sh_reg;
    logic [1:0] sh_next;

    // load wins over shift; msb sits in the output position
    assign sh_next = load  ? code :
                     shift ? {sh_reg[0], 1'b0} : sh_reg;
    assign bit_out = sh_reg[1];

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            sh_reg <= 2'h0;
        end else begin
            sh_reg <= sh_next;
        end
    end
endmodule : afc_id_shifter

// ===== verilog/afc_config_regs.sv
// configuration register bank of the audio function
`timescale 1ns/10ps
module afc_config_regs
    import afc_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // configuration space access, 16-bit word lane
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [1:0]  CFG_BE,
    input  wire logic [15:0] CFG_WDATA,
    output logic [15:0]      CFG_RDATA,
    // interrupt combining
    input  wire logic        AUDIO_IRQ,
    input  wire logic        SHARED_IRQ_B,
    output logic             IRQ_TO_CTRL,
    // codec access and slot 0 id bits
    input  wire logic        CODEC_START,
    input  wire logic [1:0]  CODEC_SEL,
    input  wire logic        SLOT_ID_SHIFT,
    output logic             LINK_SERIAL_OUT,
    // decode state toward the bars
    output logic             IO_ACCESS_ENABLE_CMD,
    output logic             IO_DECODE_UNLOCK,
    output logic [15:0]      MIXER_IO_BASE,
    output logic [15:0]      BM_IO_BASE
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no power state input here: d3hot to d0 never touches these
    logic [15:0] subsystem_ident_reg;
    logic [15:0] subsystem_ident_next;
    logic        subsys_locked_reg;
    logic [7:0]  irq_routing_note_reg;
    logic [7:0]  irq_routing_note_next;
    logic [3:0]  codec_slot_ids_reg;
    logic [3:0]  codec_slot_ids_next;
    logic        unlock_reg;
    logic        unlock_next;
    logic        io_enable_reg;
    logic        io_enable_next;
    logic [15:0] mixer_base_reg;
    logic [15:0] mixer_base_next;
    logic [15:0] bm_base_reg;
    logic [15:0] bm_base_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        irq_sync1_reg;
    logic        irq_sync2_reg;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // word decode: both bytes of the 16-bit lane share one word address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a[7:1] == o[7:1]);
    endfunction : hit

    wire [15:0] wmask = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
    wire wr_cmd    = CFG_WR && hit(CFG_ADDR, OFS_COMMAND);
    wire wr_mixer  = CFG_WR && hit(CFG_ADDR, OFS_MIXER_BAR);
    wire wr_bm     = CFG_WR && hit(CFG_ADDR, OFS_BM_BAR);
    wire wr_subsys = CFG_WR && hit(CFG_ADDR, OFS_SUBSYS);
    wire wr_irq    = CFG_WR && hit(CFG_ADDR, OFS_IRQ_LINE) && CFG_BE[0];
    wire wr_codec  = CFG_WR && hit(CFG_ADDR, OFS_CODEC_IDS) && CFG_BE[0];
    wire wr_config = CFG_WR && hit(CFG_ADDR, OFS_CONFIG) && CFG_BE[1];

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // write-once: any write with a byte lane set closes the door
    wire subsys_take = wr_subsys && !subsys_locked_reg && (CFG_BE != 2'h0);
    assign subsystem_ident_next = subsys_take ?
        ((CFG_WDATA & wmask) | (subsystem_ident_reg & ~wmask)) :
        subsystem_ident_reg;

    // kept only for software, no logic reads it
    assign irq_routing_note_next = wr_irq ? CFG_WDATA[7:0]
                                          : irq_routing_note_reg;

    // software keeps this fixed once codec traffic starts
    assign codec_slot_ids_next = wr_codec ? CFG_WDATA[3:0]
                                          : codec_slot_ids_reg;

    assign unlock_next = wr_config ? CFG_WDATA[8 + UNLOCK_BIT]
                                   : unlock_reg;

    assign io_enable_next = (wr_cmd && CFG_BE[0] && unlock_reg) ?
        CFG_WDATA[IO_ENABLE_BIT] : io_enable_reg;

    assign mixer_base_next = (wr_mixer && unlock_reg) ?
        (((CFG_WDATA & wmask) | (mixer_base_reg & ~wmask))
         & MIXER_BASE_MASK) : mixer_base_reg;
    assign bm_base_next = (wr_bm && unlock_reg) ?
        (((CFG_WDATA & wmask) | (bm_base_reg & ~wmask))
         & BM_BASE_MASK) : bm_base_reg;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [15:0] bar_type = {15'h0000, unlock_reg};
    wire [15:0] rd_mux =
        hit(CFG_ADDR, OFS_COMMAND)   ? {15'h0000, io_enable_reg} :
        hit(CFG_ADDR, OFS_MIXER_BAR) ? (mixer_base_reg | bar_type) :
        hit(CFG_ADDR, OFS_BM_BAR)    ? (bm_base_reg | bar_type) :
        hit(CFG_ADDR, OFS_SUBSYS)    ? subsystem_ident_reg :
        hit(CFG_ADDR, OFS_FIRST_FEATURE_POINTER)   ? {8'h00, FIRST_FEATURE_POINTER_VAL} :
        hit(CFG_ADDR, OFS_IRQ_LINE)  ?
            {IRQ_PIN_VAL, irq_routing_note_reg} :
        hit(CFG_ADDR, OFS_CODEC_IDS) ?
            {7'h00, unlock_reg, 4'h0, codec_slot_ids_reg} :
        hit(CFG_ADDR, OFS_PM_IDENT)  ? PM_IDENT_VAL :
        hit(CFG_ADDR, OFS_PM_FEAT)   ?
            PM_FEAT_VAL : 16'h0000;
    assign rdata_next = CFG_RD ? (rd_mux & wmask) : rdata_reg;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            subsystem_ident_reg  <= SUBSYS_RST;
            subsys_locked_reg    <= 1'b0;
            irq_routing_note_reg <= IRQ_LINE_RST;
            codec_slot_ids_reg   <= CODEC_IDS_RST[3:0];
            unlock_reg           <= CONFIG_RST[0];
            io_enable_reg        <= 1'b0;
            mixer_base_reg       <= 16'h0000;
            bm_base_reg          <= 16'h0000;
            rdata_reg            <= 16'h0000;
        end else begin
            subsystem_ident_reg  <= subsystem_ident_next;
            subsys_locked_reg    <= subsys_locked_reg | subsys_take;
            irq_routing_note_reg <= irq_routing_note_next;
            codec_slot_ids_reg   <= codec_slot_ids_next;
            unlock_reg           <= unlock_next;
            io_enable_reg        <= io_enable_next;
            mixer_base_reg       <= mixer_base_next;
            bm_base_reg          <= bm_base_next;
            rdata_reg            <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt combining
    // ------------------------------------------------------------
    // the shared line comes from a pin, so it is synchronised first
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            irq_sync1_reg <= 1'b0;
            irq_sync2_reg <= 1'b0;
        end else begin
            irq_sync1_reg <= SHARED_IRQ_B;
            irq_sync2_reg <= irq_sync1_reg;
        end
    end
    assign IRQ_TO_CTRL = AUDIO_IRQ | irq_sync2_reg;

    // ------------------------------------------------------------
    // slot 0 codec id
    // ------------------------------------------------------------
    // primary and unknown selectors send id 00
    wire [1:0] chosen_code =
        (CODEC_SEL == SEL_SECONDARY) ?
            codec_slot_ids_reg[SECOND_CODE_LSB +: 2] :
        (CODEC_SEL == SEL_TERTIARY)  ?
            codec_slot_ids_reg[THIRD_CODE_LSB +: 2] : 2'h0;

    afc_id_shifter u_shift (
        .REF_CLK (REF_CLK),
        .RSTN    (RSTN),
        .load    (CODEC_START),
        .shift   (SLOT_ID_SHIFT),
        .code    (chosen_code),
        .bit_out (LINK_SERIAL_OUT)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign CFG_RDATA            = rdata_reg;
    assign IO_ACCESS_ENABLE_CMD = io_enable_reg;
    assign IO_DECODE_UNLOCK     = unlock_reg;
    assign MIXER_IO_BASE        = mixer_base_reg | bar_type;
    assign BM_IO_BASE           = bm_base_reg | bar_type;
endmodule : afc_config_regs

// ===== verif/afc_checker.sv
// port assertions for the configuration register bank
`timescale 1ns/10ps
module afc_checker
    import afc_pkg::*;
(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    // register access
    input wire logic        CFG_RD,
    input wire logic [7:0]  CFG_ADDR,
    input wire logic [1:0]  CFG_BE,
    input wire logic [15:0] CFG_RDATA,
    // interrupt and codec id
    input wire logic        AUDIO_IRQ,
    input wire logic        SHARED_IRQ_B,
    input wire logic        IRQ_TO_CTRL,
    input wire logic        CODEC_START,
    input wire logic [1:0]  CODEC_SEL,
    input wire logic        LINK_SERIAL_OUT,
    // decode state
    input wire logic        IO_ACCESS_ENABLE_CMD,
    input wire logic        IO_DECODE_UNLOCK,
    input wire logic [15:0] MIXER_IO_BASE,
    input wire logic [15:0] BM_IO_BASE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    wire rd_word = CFG_RD && CFG_BE == 2'h3;
    first_feature_pointer_a: assert property (rd_word && CFG_ADDR == OFS_FIRST_FEATURE_POINTER
        |=> CFG_RDATA == 16'h0050) else $error("pointer read wrong");
    pm_ident_a: assert property (rd_word && CFG_ADDR == OFS_PM_IDENT
        |=> CFG_RDATA == 16'h0001) else $error("pm ident read wrong");
    pm_feat_a: assert property (rd_word && CFG_ADDR == OFS_PM_FEAT
        |=> CFG_RDATA == 16'hC9C2) else $error("pm features read wrong");
    irq_pin_a: assert property (CFG_RD && CFG_ADDR == OFS_IRQ_PIN
        && CFG_BE == 2'h2 |=> CFG_RDATA == 16'h0200)
        else $error("irq pin read wrong");
    rdata_hold_a: assert property (!CFG_RD |=> $stable(CFG_RDATA))
        else $error("read data moved without a read");
    bar_zero_a: assert property (!IO_DECODE_UNLOCK |->
        !MIXER_IO_BASE[0] && !BM_IO_BASE[0]) else $error("bar bit0 set");
    io_locked_a: assert property (!IO_DECODE_UNLOCK |=>
        $stable(IO_ACCESS_ENABLE_CMD) && $stable(MIXER_IO_BASE[15:8])
        && $stable(BM_IO_BASE[15:6])) else $error("locked io state moved");
    irq_audio_a: assert property (AUDIO_IRQ |-> IRQ_TO_CTRL)
        else $error("audio irq not passed");
    irq_shared_a: assert property (SHARED_IRQ_B [*3] |-> IRQ_TO_CTRL)
        else $error("shared irq not passed");
    irq_quiet_a: assert property ((!AUDIO_IRQ && !SHARED_IRQ_B) [*3]
        |-> !IRQ_TO_CTRL) else $error("irq without cause");
    primary_id_a: assert property (CODEC_START &&
        CODEC_SEL == SEL_PRIMARY |=> !LINK_SERIAL_OUT)
        else $error("primary id not zero");
    cover property (rd_word && CFG_ADDR == OFS_PM_FEAT);
    cover property (CODEC_START && CODEC_SEL == SEL_SECONDARY);
    cover property ($rose(IO_DECODE_UNLOCK));
endmodule : afc_checker

bind afc_config_regs afc_checker u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_RDATA(CFG_RDATA), .AUDIO_IRQ(AUDIO_IRQ),
    .SHARED_IRQ_B(SHARED_IRQ_B), .IRQ_TO_CTRL(IRQ_TO_CTRL),
    .CODEC_START(CODEC_START), .CODEC_SEL(CODEC_SEL),
    .LINK_SERIAL_OUT(LINK_SERIAL_OUT),
    .IO_ACCESS_ENABLE_CMD(IO_ACCESS_ENABLE_CMD),
    .IO_DECODE_UNLOCK(IO_DECODE_UNLOCK), .MIXER_IO_BASE(MIXER_IO_BASE),
    .BM_IO_BASE(BM_IO_BASE));

// ===== verif/afc_config_regs_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
module afc_config_regs_tb
    import afc_pkg::*;
;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0, start = 0, shift = 0;
    logic        airq = 0, sirq = 0;
    logic [7:0]  addr = 0;
    logic [1:0]  be = 0, sel = 0;
    logic [15:0] wdata = 0;
    wire logic [15:0] rdata, mbase, bbase;
    wire logic   irq, sout, ioen, unlk;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    // address, byte enables, expected read data
    localparam logic [25:0] ROWS [12] = '{{8'h2E, 2'h3, 16'h0000},
        {8'h34, 2'h1, 16'h0050}, {8'h3C, 2'h3, 16'h0200},
        {8'h40, 2'h3, 16'h0009}, {8'h50, 2'h3, 16'h0001},
        {8'h52, 2'h3, 16'hC9C2}, {8'h04, 2'h3, 16'h0000},
        {8'h10, 2'h3, 16'h0000}, {8'h14, 2'h3, 16'h0000},
        {8'h60, 2'h3, 16'h0000}, {8'h34, 2'h3, 16'h0050},
        {8'h3D, 2'h2, 16'h0200}};
    afc_config_regs u_dut (.REF_CLK(clk), .RSTN(rstn), .CFG_WR(wr),
        .CFG_RD(rd), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata),
        .CFG_RDATA(rdata), .AUDIO_IRQ(airq), .SHARED_IRQ_B(sirq),
        .IRQ_TO_CTRL(irq), .CODEC_START(start), .CODEC_SEL(sel),
        .SLOT_ID_SHIFT(shift), .LINK_SERIAL_OUT(sout),
        .IO_ACCESS_ENABLE_CMD(ioen), .IO_DECODE_UNLOCK(unlk),
        .MIXER_IO_BASE(mbase), .BM_IO_BASE(bbase));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr_cfg(input logic [7:0] a, input logic [1:0] b,
                          input logic [15:0] d);
        @(negedge clk);
        {addr, be, wdata, wr} = {a, b, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_cfg
    task automatic rd_cfg(input logic [7:0] a, input logic [1:0] b,
                          input logic [15:0] e);
        @(negedge clk);
        {addr, be, rd} = {a, b, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        chk("read data", e, rdata);
    endtask : rd_cfg
    // id bits must leave msb first, one bit per shift
    task automatic id_out(input logic [1:0] s, input logic [1:0] e);
        @(negedge clk);
        {sel, start} = {s, 1'b1};
        @(negedge clk);
        {start, shift} = 2'b01;
        chk("id first bit", {15'h0, e[1]}, {15'h0, sout});
        @(negedge clk);
        shift = 1'b0;
        chk("id second bit", {15'h0, e[0]}, {15'h0, sout});
    endtask : id_out
    task automatic do_reset();
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
    endtask : do_reset
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            rd_cfg(ROWS[i][25:18], ROWS[i][17:16], ROWS[i][15:0]);
        end
        $display("test reset values done");
        wr_cfg(8'h2E, 2'h1, 16'h12A5);
        rd_cfg(8'h2E, 2'h3, 16'h00A5);
        wr_cfg(8'h2E, 2'h3, 16'hFFFF);
        rd_cfg(8'h2E, 2'h3, 16'h00A5);
        wr_cfg(8'h3C, 2'h3, 16'hFFFF);
        rd_cfg(8'h3C, 2'h3, 16'h02FF);
        chk("irq out", 16'h0, {15'h0, irq});
        // ids are set before any codec access below
        wr_cfg(8'h40, 2'h1, 16'h00F6);
        rd_cfg(8'h40, 2'h3, 16'h0006);
        $display("test register access done");
        for (int k = 0; k < 2; k++) begin
            wr_cfg(8'h04, 2'h3, 16'h0001);
            wr_cfg(8'h10, 2'h3, 16'hFFFF);
            wr_cfg(8'h14, 2'h3, 16'hFFFF);
            chk("io enable", {15'h0, k[0]}, {15'h0, ioen});
            chk("mixer base", k ? 16'hFF01 : 16'h0, mbase);
            chk("bm base", k ? 16'hFFC1 : 16'h0, bbase);
            wr_cfg(8'h40, 2'h2, 16'h0100);
        end
        $display("test io unlock done");
        id_out(SEL_SECONDARY, 2'b10);
        id_out(SEL_TERTIARY, 2'b01);
        id_out(SEL_PRIMARY, 2'b00);
        $display("test codec id done");
        airq = 1'b1;
        #1 chk("irq out", 16'h1, {15'h0, irq});
        @(negedge clk);
        {airq, sirq} = 2'b01;
        @(negedge clk);
        chk("irq out", 16'h0, {15'h0, irq});
        @(negedge clk);
        chk("irq out", 16'h1, {15'h0, irq});
        // third cycle high so the shared-line assertion is exercised
        @(negedge clk);
        chk("irq out", 16'h1, {15'h0, irq});
        sirq = 1'b0;
        $display("test interrupt done");
        do_reset();
        chk("unlock", 16'h0, {15'h0, unlk});
        chk("io enable", 16'h0, {15'h0, ioen});
        chk("mixer base", 16'h0, mbase);
        rd_cfg(8'h40, 2'h3, 16'h0009);
        wr_cfg(8'h2E, 2'h3, 16'h1111);
        rd_cfg(8'h2E, 2'h3, 16'h1111);
        $display("test second reset done");
        final_report();
    end
endmodule : afc_config_regs_tb
